//--- hdl/bpc_pkg.sv
// Constants, register map, field positions and carrier types for the pack protection control.
// Assumes a single 200 MHz reference clock and analog comparators outside this logic.
// Operation
// - Battery sense below brownout threshold sets brownout flag bit 4 and asserts alert.
// - Cutoff register upper nibble selects brownout threshold, 7.975 to 12.475 V, 0.3 V.
// - Host read of status deasserts the alert raised by brownout.
// - Brownout flag clears only after release bit pulses 0-1-0, then status read.
// - Cutoff register lower nibble selects shutdown threshold, 6.475 to 10.975 V, 0.3 V.
// - Below shutdown with no pack voltage: sleep flag bit 5, all gates off.
// - Sleep flag clears by itself once voltage rises above shutdown threshold.
// - Entering or leaving sleep never changes the alert output.
// - Charge overcurrent and overload thresholds: own registers, 50 to 205 mV, default 50.
// - One short threshold for both directions, 100 to 475 mV, default 100.
// - Overcurrent and overload delays independent, 1 to 31 ms in 2 ms, default 1.
// - Short delay 0 to 915 us in 61 us steps, default zero.
// - A current fault acts on gates only after its blanking delay elapses.
// - Confirmed current fault turns charge and discharge off, precharge on.
// - Status bits 0 to 3 report the four current faults and change alert.
// - Fault protection stays latched until release bit is set then cleared.
// - Releasing while the fault persists re-enters protection.
// - Cell select bits 0 to 1 choose the translated series cell.
// - Cell select bits 2 to 3 choose the measurement mode, offset modes included.
// - External time base activity holds off internal oscillator; it resumes if edges stop.
// - Every register returns to its default at reset.
package bpc_pkg;

  localparam int REF_HZ = 200_000_000;
  localparam int TB_HZ  = 32_768;

  localparam logic [6:0] I2C_ADDR = 7'h20;

  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] REG_CUTOFF  = 8'h02;
  localparam logic [7:0] REG_OLVD    = 8'h03;
  localparam logic [7:0] REG_CHARGE_OC = 8'h04;
  localparam logic [7:0] REG_OCDLY   = 8'h05;
  localparam logic [7:0] REG_CELLSEL = 8'h06;
  localparam logic [7:0] REG_SCTHR   = 8'h07;
  localparam logic [7:0] REG_SCDLY   = 8'h08;

  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CUTOFF  = 8'h00;
  localparam logic [7:0] RST_OCV     = 8'h00;
  localparam logic [7:0] RST_OCDLY   = 8'h00;
  localparam logic [7:0] RST_CELLSEL = 8'h00;
  localparam logic [7:0] RST_SCTHR   = 8'h00;
  localparam logic [7:0] RST_SCDLY   = 8'h00;

  // Status bit positions; the low four also index the blanking channels.
  localparam int ST_DIS_SHORT = 0;
  localparam int ST_CHARGE_SHORT = 1;
  localparam int ST_OVERLOAD  = 2;
  localparam int ST_OVERCUR   = 3;
  localparam int ST_BROWNOUT  = 4;
  localparam int ST_SLEEP     = 5;

  localparam int CT_RELEASE  = 0;
  localparam int CT_DISCHARGE_ON  = 1;
  localparam int CT_CHARGE_ON     = 2;
  localparam int CT_PRECHARGE_OFF = 3;
  localparam int CT_LED_EN   = 5;
  localparam int CT_TOUT_EN  = 6;

  localparam int OC_BASE_US = 1000;
  localparam int OC_STEP_US = 2000;
  localparam int SC_STEP_US = 61;
  localparam int OC_BASE_TK = (OC_BASE_US * TB_HZ + 999_999) / 1_000_000;
  localparam int OC_STEP_TK = (OC_STEP_US * TB_HZ + 999_999) / 1_000_000;
  localparam int SC_STEP_TK = (SC_STEP_US * TB_HZ + 999_999) / 1_000_000;
  localparam int DLY_W      = 11;

  localparam int INT_DIV     = REF_HZ / TB_HZ;
  localparam int EXT_TIMEOUT = 2 * INT_DIV;

  typedef struct packed {
    logic [3:0] faultCmp;
    logic       brownout;
    logic       belowShutdown;
    logic       packPresent;
  } bpc_cmp_s;

  typedef struct packed {
    logic charge;
    logic discharge;
    logic precharge;
  } bpc_gate_s;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_PTR,
    BUS_WDATA,
    BUS_RDATA
  } bpc_bus_e;

  function automatic logic [DLY_W-1:0] ocTicks(input logic [3:0] code);
    return DLY_W'(OC_BASE_TK + OC_STEP_TK * int'(code));
  endfunction

  function automatic logic [DLY_W-1:0] scTicks(input logic [3:0] code);
    return DLY_W'(SC_STEP_TK * int'(code));
  endfunction

endpackage

//--- hdl/bpc_timebase.sv
// Delay time base: external 32.768 kHz input when it toggles, internal divider otherwise.
// Assumes the external input is asynchronous to ref_clk.
`timescale 1ns/1ps
module bpc_timebase #(
  parameter int INT_DIV     = bpc_pkg::INT_DIV,
  parameter int EXT_TIMEOUT = bpc_pkg::EXT_TIMEOUT
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic extIn,
  output logic      tick,
  output logic      extActive
);
  import bpc_pkg::*;

  localparam int CW = $clog2(EXT_TIMEOUT + 1);

  logic          extMeta;
  logic          extSync;
  logic          extPrev;
  logic [CW-1:0] quietCnt;
  logic [CW-1:0] intCnt;
  logic          extEdge;
  logic          intWrap;

  assign extEdge = extSync & ~extPrev;
  assign intWrap = (intCnt == CW'(INT_DIV - 1));

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // The pin idles high on its pull-up, so the syncs reset high to avoid a false edge.
      extMeta <= 1'b1;
      extSync <= 1'b1;
      extPrev <= 1'b1;
    end
    else if (ce)
    begin
      extMeta <= extIn;
      extSync <= extMeta;
      extPrev <= extSync;
    end
  end

  // A missing edge for two nominal periods hands timing back to the internal divider.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      quietCnt  <= '0;
      extActive <= 1'b0;
    end
    else if (ce)
    begin
      if (extEdge)
      begin
        quietCnt  <= '0;
        extActive <= 1'b1;
      end
      else if (quietCnt == CW'(EXT_TIMEOUT))
        extActive <= 1'b0;
      else
        quietCnt <= quietCnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      intCnt <= '0;
    else if (ce)
    begin
      if (extActive || intWrap)
        intCnt <= '0;
      else
        intCnt <= intCnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tick <= 1'b0;
    else if (ce)
      tick <= extActive ? extEdge : intWrap;
  end

endmodule

//--- hdl/bpc_control.sv
// Pack protection control: two-wire register slave, thresholds, blanking, fault latch, gates.
// Assumes comparator levels and the two-wire pins arrive asynchronously to ref_clk.
`timescale 1ns/1ps
module bpc_control #(
  parameter int INT_DIV     = bpc_pkg::INT_DIV,
  parameter int EXT_TIMEOUT = bpc_pkg::EXT_TIMEOUT
) (
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          sclIn,
  input  wire logic          sdaIn,
  output logic               sdaOut,
  output logic               sdaOe,
  input  wire bpc_pkg::bpc_cmp_s cmpRaw,
  input  wire logic          externalTimebaseInput,
  output bpc_pkg::bpc_gate_s gates,
  output logic               alertNOut,
  output logic               alertNOe,
  output logic               sleepActive,
  output logic [7:0]         voltageCutoffThresholds,
  output logic [7:0]         dischargeOverloadThreshold,
  output logic [7:0]         chargeOvercurrentThreshold,
  output logic [7:0]         shortThresholdSetting,
  output logic [7:0]         cellSelect,
  output logic               ledEnable,
  output logic               thermEnable
);
  import bpc_pkg::*;

  logic           sclMeta;
  logic           sclSync;
  logic           sclPrev;
  logic           sdaMeta;
  logic           sdaSync;
  logic           sdaPrev;
  bpc_cmp_s       cmpMeta;
  bpc_cmp_s       cmpSync;
  bpc_bus_e       busState;
  logic           ackPhase;
  logic [3:0]     bitCnt;
  logic [7:0]     shiftIn;
  logic [7:0]     shiftOut;
  logic           rnw;
  logic           masterNack;
  logic [7:0]     ptr;
  logic           wrStrobe;
  logic           rdStatus;
  logic [7:0]     control;
  logic [7:0]     overcurrentDelaySetting;
  logic [7:0]     shortDelaySetting;
  logic           relPrev;
  logic           releaseFall;
  logic           tick;
  logic [DLY_W-1:0] dlyCnt [4];
  logic [DLY_W-1:0] dlyLimit [4];
  logic [3:0]     confirmed;
  logic [3:0]     faultStatus;
  logic           brownoutFlag;
  logic           brownArmed;
  logic           brownClear;
  logic           sleepFlag;
  logic           newEvent;
  logic [7:0]     statusValue;
  logic [7:0]     rdValue;
  logic           startDet;
  logic           stopDet;
  logic           sclRise;
  logic           sclFall;

  assign startDet = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign stopDet  = sclSync & sclPrev & ~sdaPrev & sdaSync;
  assign sclRise  = sclSync & ~sclPrev;
  assign sclFall  = ~sclSync & sclPrev;

  bpc_timebase #(
    .INT_DIV     (INT_DIV),
    .EXT_TIMEOUT (EXT_TIMEOUT)
  ) u_timebase (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .ce        (ce),
    .extIn     (externalTimebaseInput),
    .tick      (tick),
    .extActive ()
  );

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
      cmpMeta <= '0;
      cmpSync <= '0;
    end
    else if (ce)
    begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
      cmpMeta <= cmpRaw;
      cmpSync <= cmpMeta;
    end
  end

  assign statusValue = {2'h0, sleepFlag, brownoutFlag, faultStatus};

  function automatic logic [7:0] readReg(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      REG_STATUS:  v = statusValue;
      REG_CONTROL: v = control;
      REG_CUTOFF:  v = voltageCutoffThresholds;
      REG_OLVD:    v = dischargeOverloadThreshold;
      REG_CHARGE_OC: v = chargeOvercurrentThreshold;
      REG_OCDLY:   v = overcurrentDelaySetting;
      REG_CELLSEL: v = cellSelect;
      REG_SCTHR:   v = shortThresholdSetting;
      REG_SCDLY:   v = shortDelaySetting;
      default:     v = 8'h00;
    endcase
    return v;
  endfunction

  assign rdValue = readReg(ptr);

  // Byte-level slave. The pointer is not advanced, so repeated data bytes hit one register.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      busState   <= BUS_IDLE;
      ackPhase   <= 1'b0;
      bitCnt     <= 4'h0;
      shiftIn    <= 8'h00;
      shiftOut   <= 8'h00;
      rnw        <= 1'b0;
      masterNack <= 1'b0;
      ptr        <= 8'h00;
      sdaOe      <= 1'b0;
      wrStrobe   <= 1'b0;
      rdStatus   <= 1'b0;
    end
    else if (ce)
    begin
      wrStrobe <= 1'b0;
      rdStatus <= 1'b0;
      if (startDet)
      begin
        busState <= BUS_ADDR;
        ackPhase <= 1'b0;
        bitCnt   <= 4'h0;
        sdaOe    <= 1'b0;
      end
      else if (stopDet)
      begin
        busState <= BUS_IDLE;
        sdaOe    <= 1'b0;
      end
      else if (busState != BUS_IDLE)
      begin
        if (sclRise)
        begin
          if (!ackPhase)
          begin
            shiftIn <= {shiftIn[6:0], sdaSync};
            bitCnt  <= bitCnt + 4'h1;
          end
          else if (busState == BUS_RDATA)
            masterNack <= sdaSync;
        end
        else if (sclFall)
        begin
          if (!ackPhase && bitCnt == 4'h8)
          begin
            ackPhase <= 1'b1;
            bitCnt   <= 4'h0;
            unique case (busState)
              BUS_ADDR:
              begin
                if (shiftIn[7:1] == I2C_ADDR)
                begin
                  sdaOe <= 1'b1;
                  rnw   <= shiftIn[0];
                end
                else
                  busState <= BUS_IDLE;
              end
              BUS_PTR:
              begin
                sdaOe <= 1'b1;
                ptr   <= shiftIn;
              end
              BUS_WDATA:
              begin
                sdaOe    <= 1'b1;
                wrStrobe <= 1'b1;
              end
              BUS_RDATA: sdaOe <= 1'b0;
              BUS_IDLE:  sdaOe <= 1'b0;
            endcase
          end
          else if (ackPhase)
          begin
            ackPhase <= 1'b0;
            sdaOe    <= 1'b0;
            if ((busState == BUS_ADDR && rnw) || (busState == BUS_RDATA && !masterNack))
            begin
              busState <= BUS_RDATA;
              shiftOut <= rdValue;
              sdaOe    <= ~rdValue[7];
              rdStatus <= (ptr == REG_STATUS);
            end
            else if (busState == BUS_RDATA)
              busState <= BUS_IDLE;
            else if (busState == BUS_ADDR)
              busState <= BUS_PTR;
            else
              busState <= BUS_WDATA;
          end
          else if (busState == BUS_RDATA)
          begin
            shiftOut <= {shiftOut[6:0], 1'b0};
            sdaOe    <= ~shiftOut[6];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      control                    <= RST_CONTROL;
      voltageCutoffThresholds    <= RST_CUTOFF;
      dischargeOverloadThreshold <= RST_OCV;
      chargeOvercurrentThreshold <= RST_OCV;
      overcurrentDelaySetting    <= RST_OCDLY;
      cellSelect                 <= RST_CELLSEL;
      shortThresholdSetting      <= RST_SCTHR;
      shortDelaySetting          <= RST_SCDLY;
    end
    else if (ce && wrStrobe)
    begin
      unique case (ptr)
        REG_CONTROL: control <= shiftIn;
        REG_CUTOFF:  voltageCutoffThresholds <= shiftIn;
        REG_OLVD:    dischargeOverloadThreshold <= shiftIn;
        REG_CHARGE_OC: chargeOvercurrentThreshold <= shiftIn;
        REG_OCDLY:   overcurrentDelaySetting <= shiftIn;
        REG_CELLSEL: cellSelect <= shiftIn;
        REG_SCTHR:   shortThresholdSetting <= shiftIn;
        REG_SCDLY:   shortDelaySetting <= shiftIn;
        default:     control <= control;
      endcase
    end
  end

  always_comb
  begin
    dlyLimit[ST_DIS_SHORT] = scTicks(shortDelaySetting[3:0]);
    dlyLimit[ST_CHARGE_SHORT] = scTicks(shortDelaySetting[3:0]);
    dlyLimit[ST_OVERLOAD]  = ocTicks(overcurrentDelaySetting[7:4]);
    dlyLimit[ST_OVERCUR]   = ocTicks(overcurrentDelaySetting[3:0]);
    for (int i = 0; i < 4; i++)
      confirmed[i] = cmpSync.faultCmp[i] && (dlyCnt[i] >= dlyLimit[i]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        dlyCnt[i] <= '0;
    end
    else if (ce)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!cmpSync.faultCmp[i])
          dlyCnt[i] <= '0;
        else if (tick && dlyCnt[i] < dlyLimit[i])
          dlyCnt[i] <= dlyCnt[i] + DLY_W'(1);
      end
    end
  end

  assign releaseFall = relPrev & ~control[CT_RELEASE];
  assign newEvent    = (|(confirmed & ~faultStatus)) | (cmpSync.brownout & ~brownoutFlag);
  assign brownClear  = rdStatus & brownArmed;

  // Setting wins over every clear, so a fault present at release latches again.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      relPrev     <= 1'b0;
      faultStatus <= 4'h0;
    end
    else if (ce)
    begin
      relPrev <= control[CT_RELEASE];
      if (releaseFall)
        faultStatus <= confirmed;
      else
        faultStatus <= faultStatus | confirmed;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      brownoutFlag <= 1'b0;
      brownArmed   <= 1'b0;
    end
    else if (ce)
    begin
      brownoutFlag <= cmpSync.brownout | (brownoutFlag & ~brownClear);
      // A release seen before the flag was set does not count towards clearing it.
      if (releaseFall && brownoutFlag)
        brownArmed <= 1'b1;
      else if (brownClear)
        brownArmed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      sleepFlag <= 1'b0;
    else if (ce)
      sleepFlag <= cmpSync.belowShutdown & ~cmpSync.packPresent;
  end

  // The alert ignores sleep entirely; only fault and brownout events raise it.
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      alertNOe <= 1'b0;
    else if (ce)
      alertNOe <= newEvent | (alertNOe & ~rdStatus);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      gates       <= '0;
      sleepActive <= 1'b0;
      ledEnable   <= 1'b0;
      thermEnable <= 1'b0;
      sdaOut      <= 1'b0;
      alertNOut   <= 1'b0;
    end
    else if (ce)
    begin
      sleepActive <= sleepFlag;
      ledEnable   <= control[CT_LED_EN];
      thermEnable <= control[CT_TOUT_EN];
      if (sleepFlag)
        gates <= '0;
      else if (|faultStatus)
        gates <= '{charge: 1'b0, discharge: 1'b0, precharge: 1'b1};
      else
        gates <= '{charge: control[CT_CHARGE_ON], discharge: control[CT_DISCHARGE_ON],
                   precharge: ~control[CT_PRECHARGE_OFF]};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !ce);

  a_brown_alert: assert property ($rose(brownoutFlag) |-> alertNOe)
    else $error("Brownout flag rose without alert.");
  a_read_clears: assert property (rdStatus && !newEvent |=> !alertNOe)
    else $error("Status read did not release alert.");
  a_brown_hold: assert property (brownoutFlag && !brownArmed |=> brownoutFlag)
    else $error("Brownout flag cleared without release sequence.");
  a_sleep_gates: assert property (sleepFlag |=> gates == '0)
    else $error("Gates not off during sleep.");
  a_sleep_auto: assert property (!cmpSync.belowShutdown |=> !sleepFlag)
    else $error("Sleep flag stayed above threshold.");
  a_sleep_alert: assert property (!newEvent && !rdStatus |=> $stable(alertNOe))
    else $error("Alert changed without an event.");
  a_short_zero: assert property (shortDelaySetting[3:0] == 4'h0
      && cmpSync.faultCmp[ST_DIS_SHORT] |=> faultStatus[ST_DIS_SHORT])
    else $error("Zero delay short not latched next cycle.");
  a_blank_wait: assert property ($rose(faultStatus[ST_OVERCUR]) |->
      $past(dlyCnt[ST_OVERCUR]) >= $past(dlyLimit[ST_OVERCUR]))
    else $error("Overcurrent latched before blanking delay.");
  a_fault_gates: assert property (|faultStatus && !sleepFlag |=>
      !gates.charge && !gates.discharge && gates.precharge)
    else $error("Fault did not force gate state.");
  a_fault_latch: assert property (|faultStatus && !releaseFall |=> |faultStatus)
    else $error("Fault latch dropped without release.");
  a_blank_restart: assert property (!cmpSync.faultCmp[ST_OVERLOAD] |=>
      dlyCnt[ST_OVERLOAD] == '0)
    else $error("Blanking counter did not restart.");

  c_brown_cleared: cover property (brownoutFlag ##1 !brownoutFlag);
  c_relatch: cover property (releaseFall && |confirmed);
  c_status_read: cover property (rdStatus && alertNOe);
  c_write: cover property (wrStrobe && ptr == REG_CONTROL);

endmodule

//--- verification/bpc_host_model.sv
// Two-wire bus master that stands in for the battery management host.
// Assumes the bench resolves the open-drain data line with its pull-up.
`timescale 1ns/1ps
module bpc_host_model #(
  parameter int P = 8
) (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaRel
);
  import bpc_pkg::*;
  logic nak = 1'b0;
  initial
  begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Data moves a few cycles after the clock falls so that it never races the fall.
  task automatic bitx(input logic b, output logic r);
    sdaRel <= b;
    hc(P);
    scl <= 1'b1;
    hc(P);
    r = sdaLine;
    scl <= 1'b0;
    hc(4);
  endtask
  task automatic start();
    sdaRel <= 1'b1;
    hc(P);
    scl <= 1'b1;
    hc(P);
    sdaRel <= 1'b0;
    hc(P);
    scl <= 1'b0;
    hc(4);
  endtask
  task automatic stop();
    sdaRel <= 1'b0;
    hc(P);
    scl <= 1'b1;
    hc(P);
    sdaRel <= 1'b1;
    hc(P);
  endtask
  task automatic sendb(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    nak |= r;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    start();
    sendb({I2C_ADDR, 1'b0});
    sendb(ptr);
    sendb(d);
    stop();
  endtask
  // Ends the read with a not-acknowledge so the slave goes idle.
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic r;
    start();
    sendb({I2C_ADDR, 1'b0});
    sendb(ptr);
    start();
    sendb({I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(1'b1, r);
    stop();
  endtask
endmodule

//--- verification/bpc_control_tb.sv
// Self-checking bench of the pack protection control driven by a host model.
// Assumes a short time base divider so that blanking delays fit the run.
`timescale 1ns/1ps
module bpc_control_tb;
  import bpc_pkg::*;
  localparam int DIV = 20;
  logic       ref_clk;
  logic       srst;
  logic       scl;
  logic       sdaRel;
  logic       sdaOe;
  logic       sdaOut;
  logic       alertOe;
  logic       alertNOut;
  logic       ce = 1'b1;
  logic       extRun = 1'b0;
  logic [3:0] extPh = 4'h0;
  wire logic  alertNOe;
  logic       sleepActive;
  logic       ledEnable;
  logic       thermEnable;
  logic [7:0] vct, dot, cot, sts, cel, rv, ctl;
  wire logic  sdaLine;
  bpc_cmp_s   cmp;
  bpc_gate_s  gates;
  int         n_errors = 0;
  int         checked = 0;
  // Both pins are open drain on pull-ups; the alert net is high while the pin is pulled low.
  assign sdaLine  = sdaRel & (~sdaOe | sdaOut);
  assign alertNOe = alertOe & ~alertNOut;
  always @(posedge ref_clk)
    if (extRun)
      extPh <= extPh + 4'h1;
  bpc_control #(.INT_DIV(DIV), .EXT_TIMEOUT(50)) i_dut (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .cmpRaw(cmp), .externalTimebaseInput(extPh[3]), .gates(gates),
    .alertNOut(alertNOut), .alertNOe(alertOe), .sleepActive(sleepActive),
    .voltageCutoffThresholds(vct), .dischargeOverloadThreshold(dot),
    .chargeOvercurrentThreshold(cot), .shortThresholdSetting(sts), .cellSelect(cel),
    .ledEnable(ledEnable), .thermEnable(thermEnable));
  bpc_host_model #(.P(8)) i_host (
    .ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaRel(sdaRel));
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] gexp(input logic [7:0] c);
    return {5'h00, c[2], c[1], ~c[3]};
  endfunction
  function automatic int ocCyc(input int code);
    return (33 + 66 * code) * DIV;
  endfunction
  function automatic logic [7:0] portv(input int a);
    case (a)
      2: return vct;
      3: return dot;
      4: return cot;
      6: return cel;
      7: return sts;
      default: return rv;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string s);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp, input string s);
    chk8({7'h00, got}, {7'h00, exp}, s);
  endtask
  task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
    i_host.rd(ptr, rv);
    chk8(rv, exp, "register");
  endtask
  task automatic rel();
    i_host.wr(REG_CONTROL, ctl | 8'h01);
    i_host.wr(REG_CONTROL, ctl);
  endtask
  // The second rise restarts the count, so a counter that kept running would trip early.
  task automatic blank(input int idx, input int dly);
    cmp.faultCmp[idx] <= 1'b1;
    cyc(dly - 60);
    chk8({5'h00, gates}, gexp(ctl), "gate");
    cmp.faultCmp[idx] <= 1'b0;
    cyc(4);
    cmp.faultCmp[idx] <= 1'b1;
    cyc(dly - 60);
    chkf(alertNOe, 1'b0, "alert");
    cyc(120);
    chk8({5'h00, gates}, 8'h01, "gate");
    chkf(alertNOe, 1'b1, "alert");
    cmp.faultCmp[idx] <= 1'b0;
    rdc(REG_STATUS, 8'h01 << idx);
    chk8({5'h00, gates}, 8'h01, "gate");
    rel();
    chk8({5'h00, gates}, gexp(ctl), "gate");
  endtask
  task automatic tdone(input string s);
    $display("Test %s done", s);
  endtask
  task automatic finish_test();
    $display("Counts: %0d checks, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    cmp = '0;
    srst = 1'b1;
    void'($urandom(88));
    cyc(20);
    srst <= 1'b0;
    cyc(4);
    chk8({5'h00, gates}, gexp(8'h00), "gate");
    for (int a = 1; a <= 8; a++)
    begin
      logic [7:0] v;
      v = (a == 1) ? 8'($urandom) & 8'h7e : 8'($urandom);
      if (a == 1)
        ctl = v;
      i_host.wr(8'(a), v);
      rdc(8'(a), v);
      chk8(portv(a), v, "port");
    end
    chk8({5'h00, gates}, gexp(ctl), "gate");
    chkf(ledEnable, ctl[5], "led");
    chkf(thermEnable, ctl[6], "therm");
    i_host.wr(REG_STATUS, 8'hff);
    rdc(REG_STATUS, 8'h00);
    i_host.wr(8'h09, 8'h5a);
    rdc(8'h09, 8'h00);
    chkf(i_host.nak, 1'b0, "ack");
    srst <= 1'b1;
    cyc(20);
    srst <= 1'b0;
    cyc(4);
    for (int a = 0; a <= 8; a++)
      rdc(8'(a), 8'h00);
    tdone("registers");
    ctl = 8'h06;
    i_host.wr(REG_CONTROL, ctl);
    for (int i = 0; i < 2; i++)
    begin
      cmp.faultCmp[i] <= 1'b1;
      cyc(8);
      chk8({5'h00, gates}, 8'h01, "gate");
      rel();
      chk8({5'h00, gates}, 8'h01, "gate");
      rdc(REG_STATUS, 8'h01 << i);
      cmp.faultCmp[i] <= 1'b0;
      rel();
      chk8({5'h00, gates}, gexp(ctl), "gate");
    end
    tdone("short");
    extRun <= 1'b1;
    i_host.wr(REG_OCDLY, 8'h10);
    i_host.wr(REG_SCDLY, 8'h0f);
    // A 16-cycle external period beats the 20-cycle divider, so these ticks must be external.
    blank(3, 33 * 16);
    extRun <= 1'b0;
    blank(2, ocCyc(1));
    blank(0, 30 * DIV);
    tdone("blanking");
    ce <= 1'b0;
    cmp.brownout <= 1'b1;
    cyc(8);
    chkf(alertNOe, 1'b0, "frozen");
    ce <= 1'b1;
    cyc(8);
    chkf(alertNOe, 1'b1, "alert");
    rdc(REG_STATUS, 8'h10);
    chkf(alertNOe, 1'b0, "alert");
    cmp.brownout <= 1'b0;
    rdc(REG_STATUS, 8'h10);
    rel();
    i_host.rd(REG_STATUS, rv);
    rdc(REG_STATUS, 8'h00);
    tdone("brownout");
    cmp.belowShutdown <= 1'b1;
    cmp.packPresent <= 1'b1;
    cyc(8);
    chkf(sleepActive, 1'b0, "sleep");
    cmp.packPresent <= 1'b0;
    cyc(8);
    chkf(sleepActive, 1'b1, "sleep");
    chk8({5'h00, gates}, 8'h00, "gate");
    chkf(alertNOe, 1'b0, "alert");
    rdc(REG_STATUS, 8'h20);
    cmp.belowShutdown <= 1'b0;
    cyc(8);
    chkf(sleepActive, 1'b0, "sleep");
    chkf(alertNOe, 1'b0, "alert");
    chk8({5'h00, gates}, gexp(ctl), "gate");
    tdone("sleep");
    finish_test();
  end
endmodule
